/* File: logic/gsc_regs.svh */
// Register offsets, field positions, reset values and widths of the status block
`ifndef GSC_REGS_SVH
`define GSC_REGS_SVH
`define GSC_ADDR_W 7
`define GSC_OFS_STATUS 7'h01
`define GSC_OFS_INTERFACE_WRITE_COUNTER 7'h02
`define GSC_BIT_RESET 0
`define GSC_BIT_DRV_ERR 1
`define GSC_BIT_PUMP_UV 2
`define GSC_BIT_REGMAP 3
`define GSC_BIT_SUPPLY_UV 4
`define GSC_FLAG_W 5
`define GSC_STATUS_RST 5'h1D
`define GSC_INTERFACE_WRITE_COUNTER_RST 8'h00
`define GSC_INTERFACE_WRITE_COUNTER_W 8
`endif

/* File: logic/gsc_pkg.sv */
// Access type used by the status block logic
package gsc_pkg;
  typedef enum logic [1:0] {
    GSC_IDLE,
    GSC_READ,
    GSC_WRITE
  } gsc_acc_t;
endpackage : gsc_pkg

/* File: logic/gsc_counter.sv */
// Interface write counter with wrap-around
`timescale 1ns/100ps
`include "gsc_regs.svh"
module gsc_counter (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic count_pulse,
  output logic [`GSC_INTERFACE_WRITE_COUNTER_W-1:0] count
);
  typedef struct packed {
    logic [`GSC_INTERFACE_WRITE_COUNTER_W-1:0] cnt;
  } gsc_cnt_state_t;
  gsc_cnt_state_t st;
  gsc_cnt_state_t next_st;

  // Natural 8-bit wrap gives 255 -> 0
  always_comb begin
    next_st = st;
    if (count_pulse) begin
      next_st.cnt = st.cnt + 8'h01; // RULE13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st.cnt <= `GSC_INTERFACE_WRITE_COUNTER_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign count = st.cnt;

  wrap_ok_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
    clk_en && count_pulse && st.cnt == 8'hFF |=> st.cnt == 8'h00)
    else $error("counter did not wrap");
endmodule : gsc_counter

/* File: logic/gsc_status.sv */
// Global status flags and interface write counter registers
`timescale 1ns/100ps
`include "gsc_regs.svh"
// Notes on behaviour
// RULE1 - A status flag clears when a one is written to its bit and stays set until then.
// RULE2 - Bit 4 latches whenever the supply has been undervoltage since last clear or reset.
// RULE3 - After power-up the flags in bits 4, 3, 2 and 0 read one.
// RULE4 - Bit 3 sets when the register map is reset and all registers take reset values; here only the write counter and read data clear, other flags are kept.
// RULE5 - Bit 2 sets on pump undervoltage and the driver is held off while it lasts.
// RULE6 - The pump undervoltage flag stays latched after the condition ends until cleared.
// RULE7 - Bit 1 sets on driver shutdown from overtemperature or short, resetting to zero.
// RULE8 - Clearing the driver fault flag only works once temperature is below the limit.
// RULE9 - Bit 0 sets whenever the device has been reset.
// RULE10 - The 8-bit counter increments on each successful UART register write.
// RULE11 - Register reads leave the counter unchanged.
// RULE12 - The counter does not count in SPI operation.
// RULE13 - The counter rolls over from 255 to 0.
// RULE14 - Writing zero leaves a flag unchanged and unused bits read zero.
module gsc_status (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [`GSC_ADDR_W-1:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  input wire logic acc_uart,
  input wire logic regmap_reset,
  input wire logic supply_undervolt,
  input wire logic pump_undervolt,
  input wire logic driver_shutdown,
  input wire logic over_temp,
  output logic [31:0] acc_rdata,
  output logic acc_rvalid,
  output logic driver_enable
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`GSC_FLAG_W-1:0] flags;
    logic [31:0] rdata;
    logic rvalid;
    logic drv_en;
    gsc_pkg::gsc_acc_t last_acc;
  } gsc_state_t;
  gsc_state_t st;
  gsc_state_t next_st;
  logic [`GSC_INTERFACE_WRITE_COUNTER_W-1:0] interface_write_counter;
  logic count_pulse;
  logic do_write;
  logic do_read;

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [`GSC_ADDR_W-1:0] a,
                               input logic [`GSC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign do_write = acc_valid && acc_write;
  assign do_read = acc_valid && !acc_write;
  // Writes to any register count, but only over UART; reads never count
  assign count_pulse = do_write && acc_uart && !regmap_reset; // RULE10 RULE11 RULE12

  // ----------------------------------------------------------------
  // Counter instance
  // ----------------------------------------------------------------
  // Map reset waits for the clock enable so a frozen block keeps its count
  gsc_counter u_cnt ( // RULE13
    .clk_sys(clk_sys),
    .sys_rst(sys_rst || (regmap_reset && clk_en)), // RULE4
    .clk_en(clk_en),
    .count_pulse(count_pulse),
    .count(interface_write_counter)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Events are applied after the clear so a same-cycle event wins
  always_comb begin
    logic [`GSC_FLAG_W-1:0] clr;
    logic [`GSC_FLAG_W-1:0] setv;
    clr = '0;
    setv = '0;
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.last_acc = gsc_pkg::GSC_IDLE;
    if (do_write && hit(acc_addr, `GSC_OFS_STATUS)) begin
      clr = acc_wdata[`GSC_FLAG_W-1:0]; // RULE1 RULE14
      // Driver fault cannot be acknowledged while still overheated
      if (over_temp) begin
        clr[`GSC_BIT_DRV_ERR] = 1'b0; // RULE8
      end
    end
    setv[`GSC_BIT_SUPPLY_UV] = supply_undervolt; // RULE2
    setv[`GSC_BIT_PUMP_UV] = pump_undervolt; // RULE5 RULE6
    setv[`GSC_BIT_DRV_ERR] = driver_shutdown; // RULE7
    setv[`GSC_BIT_REGMAP] = regmap_reset; // RULE4
    next_st.flags = (st.flags & ~clr) | setv; // RULE1
    if (acc_valid) begin
      next_st.last_acc = acc_write ? gsc_pkg::GSC_WRITE : gsc_pkg::GSC_READ;
    end
    if (do_read) begin
      next_st.rvalid = 1'b1;
      if (hit(acc_addr, `GSC_OFS_STATUS)) begin
        next_st.rdata = {27'h0000000, st.flags}; // RULE14
      end else if (hit(acc_addr, `GSC_OFS_INTERFACE_WRITE_COUNTER)) begin
        next_st.rdata = {24'h000000, interface_write_counter}; // RULE14
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
    // Driver held off for as long as the pump is low
    next_st.drv_en = !pump_undervolt; // RULE5
    if (regmap_reset) begin
      next_st.rdata = 32'h00000000; // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset sets the power-up flags, including the device reset flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st.flags <= `GSC_STATUS_RST; // RULE3 RULE9
      st.rdata <= 32'h00000000;
      st.rvalid <= 1'b0;
      st.drv_en <= 1'b0;
      st.last_acc <= gsc_pkg::GSC_IDLE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign acc_rdata = st.rdata;
  assign acc_rvalid = st.rvalid;
  assign driver_enable = st.drv_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE1
    clk_en && do_write && hit(acc_addr, `GSC_OFS_STATUS) && acc_wdata[0]
    |=> !st.flags[`GSC_BIT_RESET])
    else $error("reset flag not cleared");
  flag_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
    clk_en && !do_write |=> (st.flags & $past(st.flags)) == $past(st.flags))
    else $error("flag lost without write");
  supply_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
    clk_en && supply_undervolt |=> st.flags[`GSC_BIT_SUPPLY_UV])
    else $error("supply flag not set");
  boot_flags_a: assert property (@(posedge clk_sys) // RULE3
    $past(sys_rst) && !sys_rst |-> st.flags == 5'h1D)
    else $error("boot flags wrong");
  regmap_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE4
    clk_en && regmap_reset |=> st.flags[`GSC_BIT_REGMAP] && interface_write_counter == 8'h00)
    else $error("regmap reset not seen");
  pump_drv_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE5
    clk_en && pump_undervolt |=> !driver_enable && st.flags[`GSC_BIT_PUMP_UV])
    else $error("driver not held off");
  pump_latch_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
    clk_en && st.flags[`GSC_BIT_PUMP_UV] && !do_write |=> st.flags[`GSC_BIT_PUMP_UV])
    else $error("pump flag dropped");
  drv_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE7
    clk_en && driver_shutdown |=> st.flags[`GSC_BIT_DRV_ERR])
    else $error("driver fault not set");
  drv_hot_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE8
    clk_en && over_temp && st.flags[`GSC_BIT_DRV_ERR] |=> st.flags[`GSC_BIT_DRV_ERR])
    else $error("driver fault cleared while hot");
  cnt_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst || regmap_reset) // RULE10
    clk_en && count_pulse |=> interface_write_counter == $past(interface_write_counter) + 8'h01)
    else $error("counter did not step");
  cnt_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst || regmap_reset) // RULE11
    clk_en && do_read |=> interface_write_counter == $past(interface_write_counter))
    else $error("read changed counter");
  cnt_spi_a: assert property (@(posedge clk_sys) disable iff (sys_rst || regmap_reset) // RULE12
    clk_en && do_write && !acc_uart |=> interface_write_counter == $past(interface_write_counter))
    else $error("counted in spi mode");
  read_fmt_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
    acc_rvalid |-> acc_rdata[31:8] == 24'h000000)
    else $error("unused bits not zero");

  uart_write_c: cover property (@(posedge clk_sys) clk_en && count_pulse);
  wrap_c: cover property (@(posedge clk_sys) clk_en && count_pulse && interface_write_counter == 8'hFF);
  hot_clear_c: cover property (@(posedge clk_sys) clk_en && over_temp && do_write);
  pump_c: cover property (@(posedge clk_sys) clk_en && pump_undervolt);
endmodule : gsc_status

/* File: test/gsc_host.sv */
// Host controller model that issues register accesses to the status block
`timescale 1ns/100ps
`include "gsc_regs.svh"
module gsc_host (
  input wire logic clk_sys,
  input wire logic [31:0] acc_rdata,
  input wire logic acc_rvalid,
  output logic acc_valid,
  output logic acc_write,
  output logic [`GSC_ADDR_W-1:0] acc_addr,
  output logic [31:0] acc_wdata,
  output logic acc_uart
);
  // Idle bus at time zero
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = 7'h00;
    acc_wdata = 32'h0;
    acc_uart = 1'b0;
  end
  // ----------------------------------------
  // One access, one idle cycle before it
  // ----------------------------------------
  // Released address and data invert so a stale value is never mistaken
  task automatic access(input logic w, input logic u, input logic [6:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    #1;
    acc_valid = 1'b1;
    acc_write = w;
    acc_uart = u;
    acc_addr = a;
    acc_wdata = d;
    @(posedge clk_sys);
    #1;
    acc_valid = 1'b0;
    acc_addr = ~a;
    acc_wdata = ~d;
    q = 32'hDEAD_BEEF;
    // Read answer is taken only while its valid pulse stands
    for (int i = 0; i < 2 && !w; i++) begin
      if (acc_rvalid === 1'b1) begin
        q = acc_rdata;
        break;
      end
      @(posedge clk_sys);
      #1;
    end
  endtask : access
endmodule : gsc_host

/* File: test/global_status_and_write_counter_tb.sv */
// Self-checking bench for the status flags and write counter
`timescale 1ns/100ps
`include "gsc_regs.svh"
module global_status_and_write_counter_tb;
  logic clk_sys, sys_rst, regmap_reset, supply_undervolt, pump_undervolt;
  logic driver_shutdown, over_temp, acc_valid, acc_write, acc_uart, acc_rvalid;
  logic driver_enable, clk_en;
  logic [`GSC_ADDR_W-1:0] acc_addr;
  logic [31:0] acc_wdata, acc_rdata, q, lfsr;
  logic [7:0] cnt;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  gsc_status dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_uart(acc_uart), .regmap_reset(regmap_reset),
    .supply_undervolt(supply_undervolt), .pump_undervolt(pump_undervolt),
    .driver_shutdown(driver_shutdown), .over_temp(over_temp), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .driver_enable(driver_enable));
  gsc_host host (.clk_sys(clk_sys), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_uart(acc_uart));
  // ----------------------------------------
  // Expectation helpers and checks
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Eight bits wide on purpose, so 255 plus one wraps to 0
  function automatic logic [7:0] cnt_after(input logic [7:0] c, input logic n);
    return c + {7'h0, n};
  endfunction : cnt_after
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic u, input logic [6:0] a, input logic [31:0] d);
    host.access(1'b1, u, a, d, q);
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [31:0] e);
    host.access(1'b0, 1'b1, a, 32'h0, q);
    chk(q, e);
  endtask : rdc
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    regmap_reset = 1'b0;
    supply_undervolt = 1'b0;
    pump_undervolt = 1'b0;
    driver_shutdown = 1'b0;
    over_temp = 1'b0;
    lfsr = 32'h4DF7;
    repeat (6) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    rdc(`GSC_OFS_STATUS, 32'h1D);
    rdc(`GSC_OFS_INTERFACE_WRITE_COUNTER, 32'h0);
    rdc(7'h05, 32'h0);
    wr(1'b1, `GSC_OFS_STATUS, 32'h0);
    rdc(`GSC_OFS_STATUS, 32'h1D);
    wr(1'b1, `GSC_OFS_STATUS, 32'hFFFF_FFFF);
    rdc(`GSC_OFS_STATUS, 32'h0);
    rdc(`GSC_OFS_INTERFACE_WRITE_COUNTER, 32'h2);
    // A write while the enable is low must not be taken or counted
    clk_en = 1'b0;
    wr(1'b1, `GSC_OFS_STATUS, 32'hFFFF_FFFF);
    clk_en = 1'b1;
    rdc(`GSC_OFS_INTERFACE_WRITE_COUNTER, 32'h2);
    supply_undervolt = 1'b1;
    pump_undervolt = 1'b1;
    driver_shutdown = 1'b1;
    over_temp = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({31'h0, driver_enable}, 32'h0);
    supply_undervolt = 1'b0;
    pump_undervolt = 1'b0;
    driver_shutdown = 1'b0;
    wr(1'b0, `GSC_OFS_STATUS, 32'h2);
    rdc(`GSC_OFS_STATUS, 32'h16);
    over_temp = 1'b0;
    wr(1'b0, `GSC_OFS_STATUS, 32'h2);
    rdc(`GSC_OFS_STATUS, 32'h14);
    chk({31'h0, driver_enable}, 32'h1);
    regmap_reset = 1'b1;
    @(posedge clk_sys);
    #1 regmap_reset = 1'b0;
    rdc(`GSC_OFS_STATUS, 32'h1C);
    rdc(`GSC_OFS_INTERFACE_WRITE_COUNTER, 32'h0);
    cnt = 8'h00;
    // Random mix of link kinds and targets; over 256 counted writes forces a wrap
    for (int i = 0; i < 600; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(lfsr[1], lfsr[0] ? `GSC_OFS_STATUS : `GSC_OFS_INTERFACE_WRITE_COUNTER, lfsr);
      cnt = cnt_after(cnt, lfsr[1]);
      if (lfsr[2]) rdc(`GSC_OFS_INTERFACE_WRITE_COUNTER, {24'h0, cnt});
    end
    sys_rst = 1'b1;
    @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    rdc(`GSC_OFS_STATUS, 32'h1D);
    print_verdict();
  end
endmodule : global_status_and_write_counter_tb
